// file: rtl/cpu_core_registers_stack.v
// Operation
// [RULE_01] accumulator also mapped at data address FFh
// [RULE_02] pointers mapped at 80h and 81h
// [RULE_03] short-direct registers mapped at 82h, 83h
// [RULE_04] indirect mode uses selected pointer as address
// [RULE_05] 12-bit counter holds next fetch address
// [RULE_06] bank register extends program space past 4096
// [RULE_07] counter increments when nothing redirects it
// [RULE_08] branch writes ALU sum of counter, offset
// [RULE_09] jump, call, vector, pop load the counter
// [RULE_10] three carry/zero pairs, one per context
// [RULE_11] interrupt entry switches pair, return restores
// [RULE_12] only active pair changes; switching keeps values
// [RULE_13] carry from carry/borrow, bit test, feeds rotate
// [RULE_14] zero set when result equals zero
// [RULE_15] reset starts in non-maskable context
// [RULE_16] six hidden 12-bit stack levels
// [RULE_17] push shifts deeper, sixth level lost
// [RULE_18] pop loads counter, levels shift up
// [RULE_19] overflow stays deepest, oldest address lost
// [RULE_20] empty return keeps stack, runs next instruction
// [RULE_21] stack holds program addresses only; each level here also keeps the flag context
// [RULE_22] data-space read returns last written value
`timescale 1ns/1ps
`include "cpu_core_regs.vh"

module cpu_core_registers_stack #(
    parameter BANK_W = 2                           // program bank switch width
) (
    // clock and reset
    input  wire                    clk,
    input  wire                    rst,
    // data-space bus
    input  wire [7:0]              dsAddr,
    input  wire                    dsWrite,
    input  wire                    dsRead,
    input  wire [7:0]              dsWdata,
    output reg  [7:0]              dsRdata,
    output reg                     dsHit,
    // instruction-side register writes
    input  wire                    instWrite,
    input  wire [7:0]              instAddr,
    input  wire [7:0]              instWdata,
    // register contents for the sequencer and ALU
    output reg  [7:0]              accumulator,
    output reg  [7:0]              pointerFirst,
    output reg  [7:0]              pointerSecond,
    output reg  [7:0]              shortDirectFirst,
    output reg  [7:0]              shortDirectSecond,
    // register-indirect addressing
    input  wire                    pointerSel,
    output reg  [7:0]              indirectAddr,
    // program counter control
    input  wire [3:0]              pcOp,
    input  wire [11:0]             jumpTarget,
    input  wire [11:0]             vectorAddr,
    input  wire [11:0]             aluSum,
    output reg  [11:0]             programCounter,
    // program bank switch
    input  wire                    bankWrite,
    input  wire [BANK_W-1:0]       bankWdata,
    output reg  [BANK_W+11:0]      fetchAddr,
    // flag update from the ALU
    input  wire                    carryUpdate,
    input  wire                    aluCarry,
    input  wire                    zeroUpdate,
    input  wire [7:0]              aluResult,
    output reg                     carryFlag,
    output reg                     zeroFlag,
    output reg  [1:0]              flagContext,
    output reg  [2:0]              stackDepth
);

    // data-space decode, shared by bus and instruction writes
    // one decoder keeps the bus and instruction views in step
    function [2:0] decodeReg;
        input [7:0] addr;
        begin
            case (addr)
                // [RULE_01] accumulator in data space
                `OFS_ACCUMULATOR:         decodeReg = `IDX_ACC;
                // [RULE_02] pointer register offsets
                `OFS_POINTER_FIRST:       decodeReg = `IDX_PTR1;
                `OFS_POINTER_SECOND:      decodeReg = `IDX_PTR2;
                // [RULE_03] short-direct offsets
                `OFS_SHORT_DIRECT_FIRST:  decodeReg = `IDX_SD1;
                `OFS_SHORT_DIRECT_SECOND: decodeReg = `IDX_SD2;
                default:                  decodeReg = `IDX_NONE;
            endcase
        end
    endfunction

    wire [2:0]         busIdx  = decodeReg(dsAddr);     // bus target
    wire [2:0]         instIdx = decodeReg(instAddr);   // instruction target

    // [RULE_16] six hidden levels
    // levels sit outside data space; software cannot address them
    reg  [11:0]        retStack [0:5];                  // hidden return levels
    // context kept per level so an interrupt return can restore it
    reg  [1:0]         ctxStack [0:5];                  // context saved per level
    reg  [BANK_W-1:0]  progBank;                        // program bank switch
    // one bit per context, indexed by flagContext
    reg  [2:0]         carryPairs;                      // carry per context
    reg  [2:0]         zeroPairs;                       // zero per context

    // next values, settled combinationally every cycle
    reg  [7:0]         next_acc;
    reg  [7:0]         next_ptr1;
    reg  [7:0]         next_ptr2;
    reg  [7:0]         next_sd1;
    reg  [7:0]         next_sd2;
    reg  [11:0]        next_pc;
    reg  [1:0]         next_ctx;
    reg  [BANK_W-1:0]  next_bank;
    reg  [2:0]         next_carryPairs;
    reg  [2:0]         next_zeroPairs;
    reg                doPush;                          // shift levels deeper
    reg                doPop;                           // shift levels upward
    integer            i;

    // data register next values; bus write last so it wins a tie
    // unmapped addresses fall to the default and change nothing
    always @* begin
        next_acc  = accumulator;
        next_ptr1 = pointerFirst;
        next_ptr2 = pointerSecond;
        next_sd1  = shortDirectFirst;
        next_sd2  = shortDirectSecond;
        // [RULE_22] instruction write stored
        if (instWrite) begin
            case (instIdx)
                `IDX_ACC:  next_acc  = instWdata;
                `IDX_PTR1: next_ptr1 = instWdata;
                `IDX_PTR2: next_ptr2 = instWdata;
                `IDX_SD1:  next_sd1  = instWdata;
                `IDX_SD2:  next_sd2  = instWdata;
                default:   next_acc  = next_acc;
            endcase
        end
        // [RULE_22] bus write stored
        if (dsWrite) begin
            case (busIdx)
                `IDX_ACC:  next_acc  = dsWdata;
                `IDX_PTR1: next_ptr1 = dsWdata;
                `IDX_PTR2: next_ptr2 = dsWdata;
                `IDX_SD1:  next_sd1  = dsWdata;
                `IDX_SD2:  next_sd2  = dsWdata;
                default:   next_acc  = next_acc;
            endcase
        end
    end

    // program counter, context and stack control
    always @* begin
        next_pc  = programCounter;
        next_ctx = flagContext;
        doPush   = 1'b0;
        doPop    = 1'b0;
        case (pcOp)
            // [RULE_07] plain sequential fetch
            `PCOP_INC:    next_pc = programCounter + 12'h001;
            // [RULE_08] sum comes back from ALU
            `PCOP_BRANCH: next_pc = aluSum;
            // [RULE_09] jump target load
            `PCOP_JUMP:   next_pc = jumpTarget;
            // [RULE_09] call target and push
            `PCOP_CALL: begin
                next_pc = jumpTarget;
                doPush  = 1'b1;
            end
            // [RULE_11] maskable entry switches pair
            `PCOP_INT: begin
                next_pc  = vectorAddr;
                next_ctx = `CTX_INT;
                doPush   = 1'b1;
            end
            // [RULE_11] non-maskable entry switches pair
            `PCOP_NMI: begin
                next_pc  = vectorAddr;
                next_ctx = `CTX_NMI;
                doPush   = 1'b1;
            end
            `PCOP_RET, `PCOP_INTERRUPT_RETURN: begin
                // a plain return pops the level but leaves the context
                // [RULE_20] empty stack: fall through
                if (stackDepth == 3'h0) begin
                    next_pc = programCounter + 12'h001;
                end else begin
                    // [RULE_18] top level into counter
                    next_pc = retStack[0];
                    doPop   = 1'b1;
                    // [RULE_11] restore earlier pair
                    if (pcOp == `PCOP_INTERRUPT_RETURN) begin
                        next_ctx = ctxStack[0];
                    end
                end
            end
            default: next_pc = programCounter;
        endcase
    end

    // flag pairs: only the pair of the current context is touched
    // an update in the cycle of a context switch lands in the
    // old pair, since flagContext is still the pre-edge value
    always @* begin
        next_carryPairs = carryPairs;
        next_zeroPairs  = zeroPairs;
        // [RULE_13] carry or borrow, or tested bit
        if (carryUpdate) begin
            next_carryPairs[flagContext] = aluCarry;
        end
        // [RULE_14] zero result detect
        if (zeroUpdate) begin
            next_zeroPairs[flagContext] = (aluResult == 8'h00);
        end
    end

    // bank switch written by the sequencer
    // the bank never rides the stack; calls leave it as it is
    always @* begin
        next_bank = progBank;
        if (bankWrite) begin
            next_bank = bankWdata;
        end
    end

    // data-space registers and indirect address
    always @(posedge clk) begin
        if (rst) begin
            accumulator       <= `RST_DATA_REG;
            pointerFirst      <= `RST_DATA_REG;
            pointerSecond     <= `RST_DATA_REG;
            shortDirectFirst  <= `RST_DATA_REG;
            shortDirectSecond <= `RST_DATA_REG;
            indirectAddr      <= `RST_DATA_REG;
        end else begin
            accumulator       <= next_acc;
            pointerFirst      <= next_ptr1;
            pointerSecond     <= next_ptr2;
            shortDirectFirst  <= next_sd1;
            shortDirectSecond <= next_sd2;
            // next pointer value, so a pointer write shows at once
            // [RULE_04] selected pointer drives address
            indirectAddr      <= pointerSel ? next_ptr2 : next_ptr1;
        end
    end

    // bus read answer, one cycle after the request
    // a read and a write of one register in a cycle give the old
    // value: the read samples the flip-flop, not the next value
    always @(posedge clk) begin
        if (rst) begin
            dsRdata <= 8'h00;
            dsHit   <= 1'b0;
        end else begin
            dsHit   <= dsRead && (busIdx != `IDX_NONE);
            // unmapped or idle reads answer zero
            dsRdata <= 8'h00;
            if (dsRead) begin
                // [RULE_22] last stored value returned
                case (busIdx)
                    `IDX_ACC:  dsRdata <= accumulator;
                    `IDX_PTR1: dsRdata <= pointerFirst;
                    `IDX_PTR2: dsRdata <= pointerSecond;
                    `IDX_SD1:  dsRdata <= shortDirectFirst;
                    `IDX_SD2:  dsRdata <= shortDirectSecond;
                    default:   dsRdata <= 8'h00;
                endcase
            end
        end
    end

    // program counter, bank, context and visible flags
    always @(posedge clk) begin
        if (rst) begin
            // reset vector is a plain choice; the bank restarts at zero
            // [RULE_09] reset vector load
            programCounter <= `RST_PC;
            progBank       <= `RST_BANK;
            fetchAddr      <= {`RST_BANK, `RST_PC};
            // [RULE_15] reset enters non-maskable context
            flagContext    <= `CTX_NMI;
            carryPairs     <= 3'h0;
            zeroPairs      <= 3'h0;
            carryFlag      <= 1'b0;
            zeroFlag       <= 1'b0;
        end else begin
            // [RULE_05] counter holds next fetch location
            programCounter <= next_pc;
            progBank       <= next_bank;
            // built from next values so it tracks the counter
            // [RULE_06] bank extends fetch address
            fetchAddr      <= {next_bank, next_pc};
            flagContext    <= next_ctx;
            // [RULE_12] switching leaves pair values
            carryPairs     <= next_carryPairs;
            zeroPairs      <= next_zeroPairs;
            // [RULE_10] expose pair of new context
            carryFlag      <= next_carryPairs[next_ctx];
            zeroFlag       <= next_zeroPairs[next_ctx];
        end
    end

    // return stack: shift register, no software pointer
    always @(posedge clk) begin
        if (rst) begin
            // cleared levels make a stray pop after reset harmless
            stackDepth <= 3'h0;
            for (i = 0; i < 6; i = i + 1) begin
                retStack[i] <= 12'h000;
                ctxStack[i] <= `CTX_NORMAL;
            end
        end else if (doPush) begin
            // [RULE_17] shift deeper, sixth lost
            for (i = 5; i > 0; i = i - 1) begin
                retStack[i] <= retStack[i-1];
                ctxStack[i] <= ctxStack[i-1];
            end
            // the counter as it stands is pushed: the sequencer must
            // already have stepped past the call
            // [RULE_21] the address is saved, with the flag context beside it
            retStack[0] <= programCounter;
            ctxStack[0] <= flagContext;
            // overflow keeps six levels; the oldest address drops
            // [RULE_19] depth saturates at deepest
            if (stackDepth != `STACK_LEVELS) begin
                stackDepth <= stackDepth + 3'h1;
            end
        end else if (doPop) begin
            // the sixth level keeps its value; depth marks it stale
            // depth never wraps: an empty return never pops
            // [RULE_18] shift toward first level
            for (i = 0; i < 5; i = i + 1) begin
                retStack[i] <= retStack[i+1];
                ctxStack[i] <= ctxStack[i+1];
            end
            stackDepth <= stackDepth - 3'h1;
        end
    end

endmodule // cpu_core_registers_stack

// file: common/cpu_core_regs.vh
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH

// data-space offsets of the core registers
`define OFS_POINTER_FIRST        8'h80
`define OFS_POINTER_SECOND       8'h81
`define OFS_SHORT_DIRECT_FIRST   8'h82
`define OFS_SHORT_DIRECT_SECOND  8'h83
`define OFS_ACCUMULATOR          8'hFF

// reset values of the data-space registers
`define RST_DATA_REG             8'h00

// internal register index, returned by the decode function
`define IDX_ACC                  3'h0
`define IDX_PTR1                 3'h1
`define IDX_PTR2                 3'h2
`define IDX_SD1                  3'h3
`define IDX_SD2                  3'h4
`define IDX_NONE                 3'h7

// program counter update commands
`define PCOP_HOLD                4'h0
`define PCOP_INC                 4'h1
`define PCOP_BRANCH              4'h2
`define PCOP_JUMP                4'h3
`define PCOP_CALL                4'h4
`define PCOP_INT                 4'h5
`define PCOP_NMI                 4'h6
`define PCOP_RET                 4'h7
`define PCOP_INTERRUPT_RETURN                4'h8

// flag contexts
`define CTX_NORMAL               2'h0
`define CTX_INT                  2'h1
`define CTX_NMI                  2'h2

// reset values of program counter and bank, and the stack level count
`define RST_PC                   12'hFFE
`define RST_BANK                 2'h0
`define STACK_LEVELS             3'h6

`endif

// file: testbench/cpu_core_registers_stack_props.sv
`timescale 1ns/1ps
// port-level checker for the core register block
module cpu_core_registers_stack_props #(
    parameter BANK_W = 2                 // program bank switch width
) (
    // clock and reset
    input wire                clk,
    input wire                rst,
    // data-space bus
    input wire [7:0]          dsAddr,
    input wire                dsRead,
    input wire                dsWrite,
    input wire [7:0]          dsWdata,
    input wire [7:0]          dsRdata,
    input wire                dsHit,
    // register contents
    input wire [7:0]          accumulator,
    input wire [7:0]          pointerFirst,
    input wire [7:0]          pointerSecond,
    input wire                pointerSel,
    input wire [7:0]          indirectAddr,
    // program counter and stack
    input wire [3:0]          pcOp,
    input wire [11:0]         jumpTarget,
    input wire [11:0]         aluSum,
    input wire [11:0]         programCounter,
    input wire [BANK_W+11:0]  fetchAddr,
    input wire [1:0]          flagContext,
    input wire [2:0]          stackDepth
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // one of the five core addresses
    wire mapped = dsAddr == 8'h80 || dsAddr == 8'h81 || dsAddr == 8'h82 || dsAddr == 8'h83 || dsAddr == 8'hFF;

    read_hit_a: assert property (dsRead && mapped |=> dsHit)
        else $error("mapped read gave no hit");
    read_miss_a: assert property (dsRead && !mapped |=> !dsHit && dsRdata == 8'h00)
        else $error("unmapped read answered");
    idle_bus_a: assert property (!dsRead |=> !dsHit && dsRdata == 8'h00)
        else $error("read data without a read");
    acc_write_a: assert property (dsWrite && dsAddr == 8'hFF |=> accumulator == $past(dsWdata))
        else $error("accumulator missed bus write");
    ptr_select_a: assert property (indirectAddr == ($past(pointerSel) ? pointerSecond : pointerFirst))
        else $error("indirect address not the chosen pointer");
    pc_inc_a: assert property (pcOp == 4'h1 |=> programCounter == $past(programCounter) + 12'h001)
        else $error("counter did not step by one");
    branch_sum_a: assert property (pcOp == 4'h2 |=> programCounter == $past(aluSum))
        else $error("branch did not take the sum");
    jump_load_a: assert property (pcOp == 4'h3 |=> programCounter == $past(jumpTarget))
        else $error("jump target not loaded");
    push_depth_a: assert property (pcOp == 4'h4 |=> stackDepth == ($past(stackDepth) == 3'h6 ? 3'h6 : $past(stackDepth) + 3'h1))
        else $error("depth wrong after call");
    empty_pop_a: assert property ((pcOp == 4'h7 || pcOp == 4'h8) && stackDepth == 3'h0 |=> stackDepth == 3'h0 && programCounter == $past(programCounter) + 12'h001)
        else $error("return from empty stack misbehaved");
    nmi_ctx_a: assert property (pcOp == 4'h6 |=> flagContext == 2'h2)
        else $error("nmi context not selected");
    fetch_join_a: assert property (fetchAddr[11:0] == programCounter && stackDepth <= 3'h6)
        else $error("fetch address or depth out of line");
endmodule // cpu_core_registers_stack_props

// file: testbench/core_alu_model.sv
`timescale 1ns/1ps
// far-side ALU: answers combinationally, as the core does within a cycle
module core_alu_model (
    // operands
    input  wire logic [11:0] programCounter,
    input  wire logic [7:0]  offset,
    input  wire logic [7:0]  opA,
    input  wire logic [7:0]  opB,
    // results
    output logic      [11:0] aluSum,
    output logic      [7:0]  aluResult,
    output logic             aluCarry
);
    assign aluSum = programCounter + {{4{offset[7]}}, offset};
    assign {aluCarry, aluResult} = {1'h0, opA} + {1'h0, opB};
endmodule // core_alu_model

// file: testbench/cpu_core_registers_stack_tb.sv
`timescale 1ns/1ps
`include "cpu_core_regs.vh"
module cpu_core_registers_stack_tb;
    // stimulus
    logic clk = 1'h0, rst = 1'h1, dsWrite = 1'h0, dsRead = 1'h0, instWrite = 1'h0, pointerSel = 1'h0;
    logic bankWrite = 1'h0, carryUpdate = 1'h0, zeroUpdate = 1'h0;
    logic [7:0] dsAddr = 8'h00, dsWdata = 8'h00, instAddr = 8'h00, instWdata = 8'h00, ofs = 8'h00, opA = 8'h00, opB = 8'h00;
    logic [3:0] pcOp = 4'h0;
    logic [11:0] jumpTarget = 12'h000, vectorAddr = 12'h000;
    logic [1:0] bankWdata = 2'h0;
    // observed
    wire [7:0] dsRdata, accumulator, pointerFirst, pointerSecond, shortDirectFirst, shortDirectSecond, indirectAddr, aluResult;
    wire dsHit, carryFlag, zeroFlag, aluCarry;
    wire [11:0] programCounter, aluSum;
    wire [13:0] fetchAddr;
    wire [1:0] flagContext;
    wire [2:0] stackDepth;
    wire [89:0] seen = {programCounter, fetchAddr, stackDepth, flagContext, carryFlag, zeroFlag, dsRdata, dsHit,
                        indirectAddr, accumulator, pointerFirst, pointerSecond, shortDirectFirst, shortDirectSecond};
    // reference state: m[0] accumulator, then pointers, then short-direct
    logic [7:0] m [5];
    logic [11:0] mpc, stk [6];
    logic [1:0] sctx [6], mctx, mbank;
    logic [2:0] mdep;
    logic mc [3], mz [3];
    logic [31:0] seed = 32'hFFFA;
    logic [7:0] tbl [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'h7F, 8'h00};
    int cyc = 0, n_fail = 0, cmp_count = 0;
    typedef struct { int due; logic [89:0] v; } note_t;
    note_t q [$];
    note_t n;

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    cpu_core_registers_stack #(.BANK_W(2)) u_cpu_core_registers_stack (.clk(clk), .rst(rst), .dsAddr(dsAddr),
        .dsWrite(dsWrite), .dsRead(dsRead), .dsWdata(dsWdata), .dsRdata(dsRdata), .dsHit(dsHit),
        .instWrite(instWrite), .instAddr(instAddr), .instWdata(instWdata), .accumulator(accumulator),
        .pointerFirst(pointerFirst), .pointerSecond(pointerSecond), .shortDirectFirst(shortDirectFirst),
        .shortDirectSecond(shortDirectSecond), .pointerSel(pointerSel), .indirectAddr(indirectAddr), .pcOp(pcOp),
        .jumpTarget(jumpTarget), .vectorAddr(vectorAddr), .aluSum(aluSum), .programCounter(programCounter),
        .bankWrite(bankWrite), .bankWdata(bankWdata), .fetchAddr(fetchAddr), .carryUpdate(carryUpdate),
        .aluCarry(aluCarry), .zeroUpdate(zeroUpdate), .aluResult(aluResult), .carryFlag(carryFlag),
        .zeroFlag(zeroFlag), .flagContext(flagContext), .stackDepth(stackDepth));
    core_alu_model u_core_alu_model (.programCounter(programCounter), .offset(ofs), .opA(opA), .opB(opB),
        .aluSum(aluSum), .aluResult(aluResult), .aluCarry(aluCarry));

    // xorshift source, fixed start
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // core register index of a data address, -1 when unmapped
    function automatic int ix(input logic [7:0] a);
        case (a)
            8'hFF: return 0;
            8'h80: return 1;
            8'h81: return 2;
            8'h82: return 3;
            8'h83: return 4;
            default: return -1;
        endcase
    endfunction
    task automatic check(input string nm, input logic [89:0] s, input logic [89:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        // a note never taken off the queue is a missed result
        if (q.size() != 0)
            n_fail++;
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reset for five cycles, strobes quiet so the first free edge only holds
    task automatic rstSeq();
        @(posedge clk);
        rst <= 1'h1;
        {pcOp, dsRead, dsWrite, instWrite, bankWrite, carryUpdate, zeroUpdate, pointerSel} <= '0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        foreach (m[i]) m[i] = `RST_DATA_REG;
        mpc = `RST_PC;
        mbank = `RST_BANK;
        mdep = 3'h0;
        mctx = `CTX_NMI;
        foreach (mc[i]) begin
            mc[i] = 1'h0;
            mz[i] = 1'h0;
        end
    endtask
    // one cycle of stimulus; the reference state advances and a note is queued
    task automatic step(input logic [3:0] op, input logic [11:0] arg, input logic [1:0] rw, input logic [7:0] a,
                        input logic iw);
        logic [31:0] r;
        logic [8:0] s9;
        logic [7:0] rd;
        int k, i;
        @(posedge clk);
        r = xs();
        pcOp <= op;
        jumpTarget <= arg;
        vectorAddr <= ~arg;
        ofs <= arg[7:0];
        {dsRead, dsWrite} <= rw;
        {dsAddr, instAddr, dsWdata, instWdata} <= {a, a, r[7:0], ~r[7:0]};
        instWrite <= iw;
        {opA, opB} <= r[23:8];
        {bankWdata, bankWrite, pointerSel, zeroUpdate, carryUpdate} <= r[29:24];
        k = ix(a);
        rd = (rw[1] && k >= 0) ? m[k] : 8'h00;
        if (k >= 0 && rw[0]) m[k] = r[7:0];
        else if (k >= 0 && iw) m[k] = ~r[7:0];
        s9 = {1'h0, r[23:16]} + {1'h0, r[15:8]};
        if (r[24]) mc[mctx] = s9[8];
        if (r[25]) mz[mctx] = s9[7:0] == 8'h00;
        if (r[27]) mbank = r[29:28];
        case (op)
            4'h1: mpc = mpc + 12'h001;
            4'h2: mpc = mpc + {{4{arg[7]}}, arg[7:0]};
            4'h3: mpc = arg;
            4'h4, 4'h5, 4'h6: begin
                for (i = 5; i > 0; i--) {stk[i], sctx[i]} = {stk[i-1], sctx[i-1]};
                {stk[0], sctx[0]} = {mpc, mctx};
                if (mdep < 3'h6) mdep++;
                mpc = (op == 4'h4) ? arg : ~arg;
                if (op != 4'h4) mctx = (op == 4'h5) ? `CTX_INT : `CTX_NMI;
            end
            4'h7, 4'h8: begin
                if (mdep == 3'h0) mpc = mpc + 12'h001;
                else begin
                    mpc = stk[0];
                    if (op == 4'h8) mctx = sctx[0];
                    for (i = 0; i < 5; i++) {stk[i], sctx[i]} = {stk[i+1], sctx[i+1]};
                    mdep--;
                end
            end
            default: ;
        endcase
        q.push_back('{cyc + 2, {mpc, mbank, mpc, mdep, mctx, mc[mctx], mz[mctx], rd, rw[1] && k >= 0,
                                r[26] ? m[2] : m[1], m[0], m[1], m[2], m[3], m[4]}});
    endtask
    task automatic rnd(input int cnt);
        logic [31:0] r;
        repeat (cnt) begin
            r = xs();
            step(r[3:0], r[15:4], r[17:16], r[18] ? tbl[r[23:21]] : r[31:24], r[20]);
        end
    endtask

    // result watcher: oldest note against the settled outputs
    always @(negedge clk) begin
        if (q.size() > 0 && q[0].due <= cyc) begin
            n = q.pop_front();
            check("counter and stack", seen[89:59], n.v[89:59]);
            check("flags", seen[58:57], n.v[58:57]);
            check("data space", seen[56:0], n.v[56:0]);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        rstSeq();
        // plain writes, write with read, reads, instruction-side writes
        foreach (tbl[i]) step(4'h0, 12'h000, 2'b01, tbl[i], 1'h0);
        foreach (tbl[i]) step(4'h0, 12'h000, 2'b11, tbl[i], 1'h1);
        foreach (tbl[i]) step(4'h0, 12'h000, 2'b10, tbl[i], 1'h0);
        foreach (tbl[i]) step(4'h0, 12'h000, 2'b00, tbl[i], 1'h1);
        // seven nested calls, then entries and returns past empty
        repeat (7) step(4'h4, xs(), 2'b10, 8'h80, 1'h0);
        step(4'h5, 12'h123, 2'b00, 8'h00, 1'h0);
        step(4'h6, 12'h456, 2'b00, 8'h00, 1'h0);
        repeat (9) step(4'h8, 12'h000, 2'b00, 8'h00, 1'h0);
        repeat (2) step(4'h7, 12'h000, 2'b00, 8'h00, 1'h0);
        for (int o = 0; o < 16; o++) step(o[3:0], xs(), 2'b10, 8'hFF, 1'h0);
        rnd(500);
        rstSeq();
        rnd(100);
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule // cpu_core_registers_stack_tb

bind cpu_core_registers_stack cpu_core_registers_stack_props #(.BANK_W(BANK_W)) u_props (.clk(clk), .rst(rst),
    .dsAddr(dsAddr), .dsRead(dsRead), .dsWrite(dsWrite), .dsWdata(dsWdata), .dsRdata(dsRdata), .dsHit(dsHit),
    .accumulator(accumulator), .pointerFirst(pointerFirst), .pointerSecond(pointerSecond),
    .pointerSel(pointerSel), .indirectAddr(indirectAddr), .pcOp(pcOp), .jumpTarget(jumpTarget),
    .aluSum(aluSum), .programCounter(programCounter), .fetchAddr(fetchAddr), .flagContext(flagContext),
    .stackDepth(stackDepth));
